/* File: logic/orh_pkg.sv */
package orh_pkg;

    // Tracked latency channels
    localparam int ORH_NCH    = 4;
    localparam int CH_TEMP    = 0;
    localparam int CH_ARP     = 1;
    localparam int CH_SP_PUSH = 2;
    localparam int CH_SP_CALL_VIA_ACCUMULATOR = 3;

    // Latencies in instruction slots
    localparam logic [1:0] LAT_ZERO         = 2'h0;
    localparam logic [1:0] LAT_TEMP_DELAYED = 2'h1;
    localparam logic [1:0] LAT_ARP_LD_STD   = 2'h1;
    localparam logic [1:0] LAT_ARP_OTHER    = 2'h1;
    localparam logic [1:0] LAT_ST0_FROM_ACC = 2'h2;
    localparam logic [1:0] LAT_ST0_POP      = 2'h3;
    localparam logic [1:0] LAT_SP_AGU       = 2'h1;
    localparam logic [1:0] LAT_SP_STORE     = 2'h1;

    // Status fields that carry write-to-use latency
    localparam int FLD_ARP  = 0;
    localparam int FLD_LEGACY_COMPAT_MODE = 1;
    localparam int FLD_CPL  = 2;
    localparam int FLD_DP   = 3;
    localparam int FLD_SXM  = 4;
    localparam int FLD_ASM  = 5;
    localparam int FLD_BLOCK_REPEAT_ACTIVE = 6;
    localparam int ORH_NFLD = 7;

    localparam int ORH_ARP_W = 3;
    localparam int ORH_CNT_W = 16;

    // Register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_STATE  = 8'h08;
    localparam logic [7:0] ADDR_COUNT  = 8'h0C;

    // Field positions
    localparam int CTRL_EN_BIT   = 0;
    localparam int STS_BRPT_BIT  = 4;
    localparam int STS_STD_BIT   = 5;
    localparam int ORH_NSTS      = 6;
    localparam int STATE_LEGACY_COMPAT_MODE    = 3;
    localparam int STATE_BLOCK_REPEAT_ACTIVE    = 4;
    localparam int STATE_BUSY    = 8;
    localparam int STATE_MASK    = 16;

    // Reset values
    localparam logic             CTRL_EN_RST = 1'b1;
    localparam logic [ORH_ARP_W-1:0] ARP_RST = 3'h0;
    localparam logic             LEGACY_COMPAT_MODE_RST    = 1'b0;

    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {TWR_NONE, TWR_PROTECTED, TWR_DELAYED} orh_twr_t;
    typedef enum logic [1:0] {ST1_NONE, ST1_PROTECTED, ST1_OTHER} orh_st1wr_t;
    typedef enum logic [2:0] {ARPW_NONE, ARPW_LD_IMM, ARPW_ST0_ACC, ARPW_ST0_POP, ARPW_OTHER} orh_arpwr_t;
    typedef enum logic [1:0] {SPW_NONE, SPW_COPY, SPW_STORE_ACC} orh_spwr_t;

endpackage : orh_pkg

/* File: logic/orh_lat_track.sv */
`timescale 1ns/1ps
module orh_lat_track
    import orh_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_ce,
    input  wire logic       i_step,
    input  wire logic       i_load,
    input  wire logic [1:0] i_lat,
    input  wire logic       i_use,
    output logic      [1:0] o_count,
    output logic            o_hazard
);

    typedef struct packed {
        logic [1:0] cnt;
        logic       hz;
    } orh_trk_t;

    orh_trk_t st_r;
    orh_trk_t st_nxt;

    // The consumer reads the old count, so a writer that is also a user checks the earlier write
    always_comb begin
        st_nxt    = st_r;
        st_nxt.hz = 1'b0;
        if (i_step) begin
            st_nxt.hz = i_use && (st_r.cnt != LAT_ZERO);
            if (i_load) begin
                st_nxt.cnt = i_lat;
            end else if (st_r.cnt != LAT_ZERO) begin
                st_nxt.cnt = st_r.cnt - 2'h1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= '0;
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    assign o_count  = st_r.cnt;
    assign o_hazard = st_r.hz;

endmodule : orh_lat_track

/* File: logic/orh_hazard_unit.sv */
// Our own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
// How it works
// - Flag temp write followed by shift/bit-test read.
// - Protected temp writes have zero latency.
// - Delayed temp writers need one slot.
// - Only listed temp consumers see latency.
// - Seven status fields carry write-to-use latency.
// - Late status-one write overwrites repeat flag.
// - Flag pointer/compat write before indirect use.
// - Immediate pointer load zero latency in compat.
// - Automatic pointer updates create no hazard.
// - Reset clears pointer select and compat bit.
// - Stack copy-load before push: conflict adds one.
// - Stack store-load needs one before call.
// - Status-zero from accumulator needs two slots.
// - Status-zero pop needs three slots.
module orh_hazard_unit
    import orh_pkg::*;
(
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_ce,
    input  wire logic                 i_hsel,
    input  wire logic [31:0]          i_haddr,
    input  wire logic [1:0]           i_htrans,
    input  wire logic                 i_hwrite,
    input  wire logic [2:0]           i_hsize,
    input  wire logic [31:0]          i_hwdata,
    input  wire logic                 i_hready,
    output logic      [31:0]          o_hrdata,
    output logic                      o_hreadyout,
    output logic                      o_hresp,
    input  wire logic                 i_issue,
    input  wire orh_twr_t             i_temp_wr,
    input  wire logic                 i_temp_use,
    input  wire orh_st1wr_t           i_st1_wr,
    input  wire logic                 i_st1_block_repeat_active_val,
    input  wire logic [ORH_NFLD-1:0]  i_stat_wr_mask,
    input  wire logic                 i_brpt_start,
    input  wire logic                 i_brpt_done,
    input  wire orh_arpwr_t           i_arp_wr,
    input  wire logic [ORH_ARP_W-1:0] i_arp_val,
    input  wire logic                 i_legacy_compat_mode_val,
    input  wire logic                 i_indirect_use,
    input  wire logic [ORH_ARP_W-1:0] i_auto_arp,
    input  wire orh_spwr_t            i_sp_wr,
    input  wire logic                 i_prev_agu_conflict,
    input  wire logic                 i_push,
    input  wire logic                 i_call_via_accumulator,
    output logic                      o_hazard,
    output logic      [ORH_ARP_W-1:0] o_aux_pointer_select,
    output logic                      o_legacy_compat_mode,
    output logic                      o_block_repeat_active
);

    typedef struct packed {
        logic                 ctrl_en;
        logic                 wr_pend;
        logic [7:0]           wr_addr;
        logic [31:0]          hrdata;
        logic [ORH_NSTS-1:0]  sts;
        logic [ORH_CNT_W-1:0] hz_cnt;
        logic [ORH_ARP_W-1:0] aux_pointer_select;
        logic                 legacy_compat_mode;
        logic                 block_repeat_active;
        logic                 late_pend;
        logic                 late_val;
        logic                 brpt_hz;
        logic [ORH_NFLD-1:0]  last_mask;
    } orh_core_t;

    orh_core_t st_r;
    orh_core_t st_nxt;

    logic [ORH_NCH-1:0] trk_load;
    logic [1:0]         trk_lat  [ORH_NCH];
    logic [ORH_NCH-1:0] trk_use;
    logic [1:0]         trk_cnt  [ORH_NCH];
    logic [ORH_NCH-1:0] trk_hz;
    logic [ORH_NCH-1:0] trk_busy;
    logic               arp_touch;
    logic [1:0]         arp_lat;
    logic               ap_take;
    logic [ORH_NSTS-1:0] events;
    logic [ORH_NSTS-1:0] sts_clr;

    // Latency decode per channel
    assign arp_touch = (i_arp_wr != ARPW_NONE) && (i_stat_wr_mask[FLD_ARP] || i_stat_wr_mask[FLD_LEGACY_COMPAT_MODE]);

    always_comb begin
        case (i_arp_wr)
            ARPW_LD_IMM:  arp_lat = st_r.legacy_compat_mode ? LAT_ZERO : LAT_ARP_LD_STD;
            ARPW_ST0_ACC: arp_lat = LAT_ST0_FROM_ACC;
            ARPW_ST0_POP: arp_lat = LAT_ST0_POP;
            ARPW_OTHER:   arp_lat = LAT_ARP_OTHER;
            default:      arp_lat = LAT_ZERO;
        endcase
    end

    always_comb begin
        trk_load[CH_TEMP]    = i_temp_wr != TWR_NONE;
        trk_lat[CH_TEMP]     = (i_temp_wr == TWR_DELAYED) ? LAT_TEMP_DELAYED : LAT_ZERO;
        trk_use[CH_TEMP]     = i_temp_use;
        trk_load[CH_ARP]     = arp_touch;
        trk_lat[CH_ARP]      = arp_lat;
        trk_use[CH_ARP]      = i_indirect_use;
        trk_load[CH_SP_PUSH] = i_sp_wr == SPW_COPY;
        trk_lat[CH_SP_PUSH]  = i_prev_agu_conflict ? LAT_SP_AGU : LAT_ZERO;
        trk_use[CH_SP_PUSH]  = i_push;
        trk_load[CH_SP_CALL_VIA_ACCUMULATOR] = i_sp_wr == SPW_STORE_ACC;
        trk_lat[CH_SP_CALL_VIA_ACCUMULATOR]  = LAT_SP_STORE;
        trk_use[CH_SP_CALL_VIA_ACCUMULATOR]  = i_call_via_accumulator;
    end

    // No interlock: hazards are only reported, the program must schedule around them
    genvar g;
    generate
        for (g = 0; g < ORH_NCH; g++) begin : g_trk
            orh_lat_track u_trk (
                .i_clk    (i_clk),
                .i_rst    (i_rst),
                .i_ce     (i_ce),
                .i_step   (i_issue),
                .i_load   (trk_load[g]),
                .i_lat    (trk_lat[g]),
                .i_use    (trk_use[g]),
                .o_count  (trk_cnt[g]),
                .o_hazard (trk_hz[g])
            );
            assign trk_busy[g] = trk_cnt[g] != LAT_ZERO;
        end
    endgenerate

    assign ap_take = i_hsel && i_htrans[1] && i_hready;
    assign events  = {(!st_r.legacy_compat_mode && (st_r.aux_pointer_select != ARP_RST)), st_r.brpt_hz, trk_hz}
                     & {ORH_NSTS{st_r.ctrl_en}};
    assign sts_clr = (st_r.wr_pend && st_r.wr_addr == ADDR_STATUS) ? i_hwdata[ORH_NSTS-1:0] : '0;

    function automatic logic [31:0] rd_mux(input logic [7:0] a, input orh_core_t s, input logic [ORH_NCH-1:0] b);
        logic [31:0] d;
        d = '0;
        if (a == ADDR_CTRL) begin
            d[CTRL_EN_BIT] = s.ctrl_en;
        end else if (a == ADDR_STATUS) begin
            d[ORH_NSTS-1:0] = s.sts;
        end else if (a == ADDR_STATE) begin
            d[ORH_ARP_W-1:0]                   = s.aux_pointer_select;
            d[STATE_LEGACY_COMPAT_MODE]                      = s.legacy_compat_mode;
            d[STATE_BLOCK_REPEAT_ACTIVE]                      = s.block_repeat_active;
            d[STATE_BUSY+ORH_NCH-1:STATE_BUSY] = b;
            d[STATE_MASK+ORH_NFLD-1:STATE_MASK] = s.last_mask;
        end else if (a == ADDR_COUNT) begin
            d[ORH_CNT_W-1:0] = s.hz_cnt;
        end
        return d;
    endfunction : rd_mux

    always_comb begin
        st_nxt         = st_r;
        st_nxt.brpt_hz = 1'b0;
        // Bus slave: zero wait states, read data registered in the address phase
        st_nxt.wr_pend = ap_take && i_hwrite && (i_hsize == HSIZE_WORD);
        if (ap_take) begin
            st_nxt.wr_addr = i_haddr[7:0];
            st_nxt.hrdata  = rd_mux(i_haddr[7:0], st_r, trk_busy);
        end
        if (st_r.wr_pend) begin
            if (st_r.wr_addr == ADDR_CTRL) begin
                st_nxt.ctrl_en = i_hwdata[CTRL_EN_BIT];
            end
        end
        // Set wins over a clear in the same cycle
        st_nxt.sts = (st_r.sts & ~sts_clr) | events;
        if (st_r.wr_pend && st_r.wr_addr == ADDR_COUNT) begin
            st_nxt.hz_cnt = '0;
        end else if ((|events[STS_BRPT_BIT:0]) && (st_r.hz_cnt != {ORH_CNT_W{1'b1}})) begin
            st_nxt.hz_cnt = st_r.hz_cnt + 16'h0001;
        end
        if (i_issue) begin
            if (i_stat_wr_mask != '0) begin
                st_nxt.last_mask = i_stat_wr_mask;
            end
            // Pointer select and compat bit
            if (arp_touch) begin
                if (i_stat_wr_mask[FLD_ARP]) begin
                    st_nxt.aux_pointer_select = i_arp_val;
                end
                if (i_stat_wr_mask[FLD_LEGACY_COMPAT_MODE]) begin
                    st_nxt.legacy_compat_mode = i_legacy_compat_mode_val;
                end
            end else if (st_r.legacy_compat_mode && i_indirect_use) begin
                st_nxt.aux_pointer_select = i_auto_arp;
            end
            // Repeat flag: late status-one write lands one slot after it issued
            st_nxt.late_pend = 1'b0;
            if (st_r.late_pend) begin
                st_nxt.block_repeat_active    = st_r.late_val;
                st_nxt.brpt_hz = i_brpt_start;
            end else if (i_brpt_start) begin
                st_nxt.block_repeat_active = 1'b1;
            end else if (i_brpt_done) begin
                st_nxt.block_repeat_active = 1'b0;
            end
            if (i_st1_wr == ST1_PROTECTED) begin
                st_nxt.block_repeat_active = i_st1_block_repeat_active_val;
            end else if (i_st1_wr == ST1_OTHER) begin
                st_nxt.late_pend = 1'b1;
                st_nxt.late_val  = i_st1_block_repeat_active_val;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r         <= '0;
            st_r.ctrl_en <= CTRL_EN_RST;
            st_r.aux_pointer_select     <= ARP_RST;
            st_r.legacy_compat_mode    <= LEGACY_COMPAT_MODE_RST;
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    assign o_hrdata              = st_r.hrdata;
    assign o_hreadyout           = 1'b1;
    assign o_hresp               = 1'b0;
    assign o_hazard              = (|trk_hz) || st_r.brpt_hz;
    assign o_aux_pointer_select  = st_r.aux_pointer_select;
    assign o_legacy_compat_mode  = st_r.legacy_compat_mode;
    assign o_block_repeat_active = st_r.block_repeat_active;

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    logic step;
    assign step = i_ce && i_issue;

    property p_temp_hz;
        step && i_temp_use && trk_busy[CH_TEMP] |=> trk_hz[CH_TEMP] ##1 !trk_hz[CH_TEMP] || $past(step);
    endproperty
    a_temp_hz: assert property (p_temp_hz) else $error("temp hazard not flagged");

    property p_temp_prot;
        step && i_temp_wr == TWR_PROTECTED |=> !trk_busy[CH_TEMP];
    endproperty
    a_temp_prot: assert property (p_temp_prot) else $error("protected temp write left latency");

    property p_temp_delay;
        step && i_temp_wr == TWR_DELAYED |=> trk_cnt[CH_TEMP] == LAT_TEMP_DELAYED;
    endproperty
    a_temp_delay: assert property (p_temp_delay) else $error("delayed temp write latency wrong");

    property p_temp_nouse;
        step && !i_temp_use |=> !trk_hz[CH_TEMP];
    endproperty
    a_temp_nouse: assert property (p_temp_nouse) else $error("temp hazard without consumer");

    property p_block_repeat_active_late;
        step && st_r.late_pend && i_brpt_start |=> st_r.brpt_hz && st_r.block_repeat_active == $past(st_r.late_val);
    endproperty
    a_block_repeat_active_late: assert property (p_block_repeat_active_late) else $error("late status write did not overwrite flag");

    property p_arp_hz;
        step && i_indirect_use && trk_busy[CH_ARP] |=> trk_hz[CH_ARP];
    endproperty
    a_arp_hz: assert property (p_arp_hz) else $error("pointer hazard not flagged");

    property p_arp_ldimm;
        step && i_arp_wr == ARPW_LD_IMM && arp_touch && st_r.legacy_compat_mode |=> !trk_busy[CH_ARP];
    endproperty
    a_arp_ldimm: assert property (p_arp_ldimm) else $error("immediate pointer load left latency");

    property p_arp_auto;
        step && st_r.legacy_compat_mode && i_indirect_use && !arp_touch |=>
            st_r.aux_pointer_select == $past(i_auto_arp) && trk_cnt[CH_ARP] <= $past(trk_cnt[CH_ARP]);
    endproperty
    a_arp_auto: assert property (p_arp_auto) else $error("automatic pointer update wrong");

    property p_std_mode;
        i_ce && st_r.ctrl_en && !st_r.legacy_compat_mode && st_r.aux_pointer_select != ARP_RST |=> st_r.sts[STS_STD_BIT];
    endproperty
    a_std_mode: assert property (p_std_mode) else $error("standard mode pointer not reported");

    property p_reset;
        $past(i_rst) |-> st_r.aux_pointer_select == ARP_RST && st_r.legacy_compat_mode == LEGACY_COMPAT_MODE_RST;
    endproperty
    a_reset: assert property (p_reset) else $error("reset did not clear pointer state");

    property p_sp_copy;
        step && i_sp_wr == SPW_COPY |=> trk_cnt[CH_SP_PUSH] == ($past(i_prev_agu_conflict) ? LAT_SP_AGU : LAT_ZERO);
    endproperty
    a_sp_copy: assert property (p_sp_copy) else $error("stack copy-load latency wrong");

    property p_sp_store;
        step && i_sp_wr == SPW_STORE_ACC |=> trk_cnt[CH_SP_CALL_VIA_ACCUMULATOR] == LAT_SP_STORE;
    endproperty
    a_sp_store: assert property (p_sp_store) else $error("stack store latency wrong");

    property p_st0_acc;
        step && arp_touch && i_arp_wr == ARPW_ST0_ACC |=> trk_cnt[CH_ARP] == LAT_ST0_FROM_ACC;
    endproperty
    a_st0_acc: assert property (p_st0_acc) else $error("status-zero accumulator latency wrong");

    property p_st0_pop;
        step && arp_touch && i_arp_wr == ARPW_ST0_POP |=> trk_cnt[CH_ARP] == LAT_ST0_POP;
    endproperty
    a_st0_pop: assert property (p_st0_pop) else $error("status-zero pop latency wrong");

    c_temp_hz: cover property (trk_hz[CH_TEMP]);
    c_brpt_hz: cover property (st_r.brpt_hz);
    c_st0_pop: cover property (step && arp_touch && i_arp_wr == ARPW_ST0_POP);
    c_sp_hz:   cover property (trk_hz[CH_SP_PUSH] || trk_hz[CH_SP_CALL_VIA_ACCUMULATOR]);

endmodule : orh_hazard_unit

/* File: verif/orh_ops.svh */
`ifndef ORH_OPS_SVH
`define ORH_OPS_SVH
// Instruction kinds the bench can place in one slot
localparam logic [4:0] NOP = 5'h00, TPR = 5'h01, TDL = 5'h02, TUS = 5'h03, S1P = 5'h04, S1O = 5'h05,
    BRS = 5'h06, CM1 = 5'h07, AIM = 5'h08, S0A = 5'h09, S0P = 5'h0A, IND = 5'h0B, SPC = 5'h0C,
    SPN = 5'h0D, SPS = 5'h0E, PSH = 5'h0F, CAL = 5'h10, CM0 = 5'h11;
typedef logic [4:0] orh_ops_t [5];
`endif

/* File: verif/orh_prog_model.sv */
`timescale 1ns/1ps
`include "orh_ops.svh"
module orh_prog_model
    import orh_pkg::*;
(
    input  wire logic [4:0] i_op,
    input  wire logic       i_go,
    input  wire logic       i_compat,
    output logic            o_issue,
    output orh_twr_t        o_temp_wr,
    output logic            o_temp_use,
    output orh_st1wr_t      o_sw1_wr,
    output logic            o_rpt_val,
    output logic [6:0]      o_mask,
    output logic            o_rpt_start,
    output logic            o_rpt_done,
    output orh_arpwr_t      o_ptr_wr,
    output logic [2:0]      o_ptr_val,
    output logic            o_cm_val,
    output logic            o_ind,
    output logic [2:0]      o_auto,
    output orh_spwr_t       o_stk_wr,
    output logic            o_agu,
    output logic            o_push,
    output logic            o_call
);
    // Decoded from the bench slot, so it only moves just after a clock edge
    always_comb begin
        o_issue = i_go;
        o_temp_wr = TWR_NONE;
        o_temp_use = 1'b0;
        o_sw1_wr = ST1_NONE;
        o_rpt_val = 1'b0;
        o_mask = 7'h00;
        o_rpt_start = 1'b0;
        o_rpt_done = 1'b0;
        o_ptr_wr = ARPW_NONE;
        o_ptr_val = 3'h0;
        o_cm_val = 1'b0;
        o_ind = 1'b0;
        o_auto = i_compat ? 3'h3 : 3'h0;
        o_stk_wr = SPW_NONE;
        o_agu = 1'b0;
        o_push = 1'b0;
        o_call = 1'b0;
        case (i_op)
            TPR: o_temp_wr = TWR_PROTECTED;
            TDL: o_temp_wr = TWR_DELAYED;
            TUS: o_temp_use = 1'b1;
            S1P: begin
                o_sw1_wr = ST1_PROTECTED;
                o_mask = 7'h40;
            end
            S1O: begin
                // Late writer before a repeat start: only when a scenario asks for it
                o_sw1_wr = ST1_OTHER;
                o_mask = 7'h40;
            end
            BRS: o_rpt_start = 1'b1;
            CM1, CM0: begin
                o_ptr_wr = ARPW_OTHER;
                o_mask = 7'h03;
                o_cm_val = (i_op == CM1);
            end
            AIM: begin
                o_ptr_wr = ARPW_LD_IMM;
                o_mask = 7'h01;
                o_ptr_val = i_compat ? 3'h5 : 3'h0;
            end
            S0A, S0P: begin
                o_ptr_wr = (i_op == S0A) ? ARPW_ST0_ACC : ARPW_ST0_POP;
                o_mask = 7'h03;
                o_ptr_val = 3'h6;
                o_cm_val = 1'b1;
            end
            IND: o_ind = 1'b1;
            SPC: begin
                o_stk_wr = SPW_COPY;
                o_agu = 1'b1;
            end
            SPN: o_stk_wr = SPW_COPY;
            SPS: o_stk_wr = SPW_STORE_ACC;
            PSH: o_push = 1'b1;
            CAL: o_call = 1'b1;
            default: ;
        endcase
    end
endmodule : orh_prog_model

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`include "orh_ops.svh"
module testbench
    import orh_pkg::*;
;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [4:0]  op = NOP;
    int          err_total = 0, checked = 0, hz_cnt = 0, cyc = 0;
    wire logic   hready, haz, hresp, cm, rpt, iss, tu, rv, bs, bd, cv, iu, ag, pu, ca;
    wire logic [2:0]  ptr, pv, aa;
    wire logic [6:0]  mk;
    wire logic [31:0] hrdata;
    wire orh_twr_t    tw;
    wire orh_st1wr_t  sw;
    wire orh_arpwr_t  pw;
    wire orh_spwr_t   kw;

    orh_hazard_unit dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(HSIZE_WORD), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_issue(iss), .i_temp_wr(tw),
        .i_temp_use(tu), .i_st1_wr(sw), .i_st1_block_repeat_active_val(rv), .i_stat_wr_mask(mk), .i_brpt_start(bs),
        .i_brpt_done(bd), .i_arp_wr(pw), .i_arp_val(pv), .i_legacy_compat_mode_val(cv), .i_indirect_use(iu),
        .i_auto_arp(aa), .i_sp_wr(kw), .i_prev_agu_conflict(ag), .i_push(pu), .i_call_via_accumulator(ca), .o_hazard(haz),
        .o_aux_pointer_select(ptr), .o_legacy_compat_mode(cm), .o_block_repeat_active(rpt));
    orh_prog_model prog (.i_op(op), .i_go(go), .i_compat(cm), .o_issue(iss), .o_temp_wr(tw),
        .o_temp_use(tu), .o_sw1_wr(sw), .o_rpt_val(rv), .o_mask(mk), .o_rpt_start(bs), .o_rpt_done(bd),
        .o_ptr_wr(pw), .o_ptr_val(pv), .o_cm_val(cv), .o_ind(iu), .o_auto(aa), .o_stk_wr(kw), .o_agu(ag),
        .o_push(pu), .o_call(ca));

    always #4 i_clk = ~i_clk;
    always @(posedge i_clk) if (haz === 1'b1) hz_cnt <= hz_cnt + 1;
    // Whole run is a few hundred cycles; the ceiling leaves wide margin
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            results();
        end
    end

    task automatic results();
        if (err_total == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : cmp

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge i_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge i_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge i_clk); while (hready !== 1'b1);
        rd = hrdata;
        cmp("hresp", 32'h0, {31'h0, hresp});
    endtask : ahb

    task automatic sts(input logic [31:0] e);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        cmp("status", e, rd);
        ahb(1'b1, ADDR_STATUS, 32'h3F);
    endtask : sts

    // Issues the slots back to back, then idles so late pulses are counted
    task automatic play(input orh_ops_t s, input int e);
        int b;
        b = hz_cnt;
        foreach (s[k]) begin
            @(posedge i_clk);
            op <= s[k];
            go <= 1'b1;
        end
        @(posedge i_clk);
        go <= 1'b0;
        repeat (4) @(posedge i_clk);
        cmp("hazard pulses", e, hz_cnt - b);
    endtask : play

    task automatic t_reset();
        cmp("pointer", 32'h0, {29'h0, ptr});
        cmp("compat", 32'h0, {31'h0, cm});
        ahb(1'b0, ADDR_CTRL, 32'h0);
        cmp("ctrl", 32'h1, rd);
        ahb(1'b0, ADDR_STATE, 32'h0);
        cmp("state", 32'h0, rd);
    endtask : t_reset

    task automatic t_temp();
        play('{TDL, TUS, NOP, NOP, NOP}, 1);
        sts(32'h1);
        play('{TDL, NOP, TUS, NOP, NOP}, 0);
        play('{TPR, TUS, NOP, NOP, NOP}, 0);
        play('{TDL, IND, PSH, NOP, NOP}, 0);
    endtask : t_temp

    task automatic t_rpt();
        play('{S1P, BRS, NOP, NOP, NOP}, 0);
        cmp("repeat flag", 32'h1, {31'h0, rpt});
        play('{S1O, BRS, NOP, NOP, NOP}, 1);
        cmp("repeat flag", 32'h0, {31'h0, rpt});
        sts(32'h10);
        ahb(1'b0, ADDR_STATE, 32'h0);
        cmp("field mask", 32'h40, {25'h0, rd[22:16]});
    endtask : t_rpt

    task automatic t_ptr();
        play('{CM1, IND, NOP, NOP, NOP}, 1);
        sts(32'h2);
        play('{AIM, IND, IND, NOP, NOP}, 0);
        cmp("pointer", 32'h3, {29'h0, ptr});
        play('{S0A, NOP, IND, NOP, NOP}, 1);
        play('{S0A, NOP, NOP, IND, NOP}, 0);
        play('{S0P, NOP, NOP, IND, NOP}, 1);
        play('{S0P, NOP, NOP, NOP, IND}, 0);
        play('{CM0, AIM, IND, NOP, NOP}, 1);
        cmp("compat", 32'h0, {31'h0, cm});
        sts(32'h2);
    endtask : t_ptr

    task automatic t_stk();
        play('{SPC, PSH, NOP, NOP, NOP}, 1);
        play('{SPN, PSH, NOP, NOP, NOP}, 0);
        play('{SPS, CAL, NOP, NOP, NOP}, 1);
        play('{SPS, NOP, CAL, NOP, NOP}, 0);
        sts(32'hC);
    endtask : t_stk

    task automatic t_bus();
        ahb(1'b1, ADDR_CTRL, 32'h0);
        play('{TDL, TUS, NOP, NOP, NOP}, 1);
        sts(32'h0);
        ahb(1'b0, ADDR_COUNT, 32'h0);
        cmp("count", 32'h8, rd);
        ahb(1'b1, ADDR_CTRL, 32'h1);
        ahb(1'b1, ADDR_COUNT, 32'h0);
        ahb(1'b0, ADDR_COUNT, 32'h0);
        cmp("count", 32'h0, rd);
        ahb(1'b1, 8'h10, 32'hFFFF);
        ahb(1'b0, 8'h10, 32'h0);
        cmp("unmapped", 32'h0, rd);
    endtask : t_bus

    initial begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset();
        t_temp();
        t_rpt();
        t_ptr();
        t_stk();
        t_bus();
        results();
    end
endmodule : testbench
